// ### include/scwp_params.svh
// Purpose: constants of the serial configuration write port
// Assumes: included by bare name from the design and the bench
// Notes: definitions only
`ifndef SCWP_PARAMS_SVH
`define SCWP_PARAMS_SVH
`define SCWP_FRAME_BITS 32
`define SCWP_CNT_W 5
`define SCWP_LAST_BIT 5'h1F
`define SCWP_HDR_LAST 5'h0B
`define SCWP_ADDR_LAST 5'h0F
`define SCWP_HEADER 12'h001
`define SCWP_ADDR_CONFIG 4'h1
`define SCWP_ADDR_OFFSET 4'h2
`define SCWP_ADDR_FULLSCALE 4'h3
`define SCWP_CFG_RESET 16'hB2FF
`define SCWP_OFS_RESET 16'h007F
`define SCWP_FSA_RESET 16'h807F
`define SCWP_BIT_DUTY 12
`define SCWP_BIT_PHASE 11
`define SCWP_BIT_SINGLE 10
`define SCWP_BIT_SWING 9
`define SCWP_BIT_EDGE 8
`endif

// ### include/scwp_pkg.sv
// Purpose: types of the serial configuration write port
// Assumes: nothing
// Notes: constants live in scwp_params.svh
package scwp_pkg;
  // field of the frame being shifted; gray along header, address, data
  typedef enum logic [1:0] {
    FIELD_HEADER = 2'b00,
    FIELD_ADDR = 2'b01,
    FIELD_DATA = 2'b11
  } frame_field_t;
endpackage

// ### design/serial_config_write_port.sv
// Purpose: write-only serial port loading three 16-bit control registers
// Assumes: sclk_in from the host; clk_in 25 MHz internal clock
// Notes: frames decoded on sclk_in, committed on clk_in via toggle
//
// Summary of operation
// - serial writes take effect only in extended control mode
// - data sampled on rising serial clock; clock may be arbitrarily slow
// - frames are 32 bits, header, address, value, msb first
// - header is eleven zeros then a one
// - four address bits msb first, then sixteen data bits
// - address 1 configuration, 2 offset, 3 full scale; rest reserved
// - next frame may start on the 33rd clock with select held
// - registers write-only and ignored in normal control mode
// - configuration bit 12 enables the duty cycle stabiliser
// - bit 11 picks double rate clock phase, reset zero
// - bit 10 zero double rate, one single rate, reset zero
// - bit 9 one standard swing, zero reduced swing, reset one
// - bit 8 one rising edge, zero falling edge, reset zero
`timescale 1ns/1ns
`include "scwp_params.svh"

module serial_config_write_port (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic port_select_n_in,
  input wire logic port_serial_input_in,
  input wire logic extended_mode_in,
  input wire logic edge_select_pin_in,
  input wire logic swing_select_pin_in,
  input wire logic single_rate_pin_in,
  output logic duty_stabilizer_enable_out,
  output logic double_rate_clock_phase_out,
  output logic single_rate_select_out,
  output logic output_swing_select_out,
  output logic output_data_clock_edge_out,
  output logic [15:0] offset_adjust_out,
  output logic [15:0] full_scale_adjust_out
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic scwp_pkg::frame_field_t field_of(
    input logic [`SCWP_CNT_W-1:0] cnt
  );
    scwp_pkg::frame_field_t f;
    f = scwp_pkg::FIELD_DATA;
    if (cnt <= `SCWP_HDR_LAST) begin
      f = scwp_pkg::FIELD_HEADER;
    end else if (cnt <= `SCWP_ADDR_LAST) begin
      f = scwp_pkg::FIELD_ADDR;
    end
    return f;
  endfunction

  function automatic logic addr_known(input logic [3:0] a);
    return (a == `SCWP_ADDR_CONFIG) || (a == `SCWP_ADDR_OFFSET) ||
           (a == `SCWP_ADDR_FULLSCALE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // serial clock domain

  // select high clears the frame position, so every access starts afresh
  wire link_rst = rst_in | port_select_n_in;

  logic [`SCWP_CNT_W-1:0] bit_count;
  logic [30:0] shift;
  logic [3:0] hold_addr;
  logic [15:0] hold_data;
  logic commit_toggle;

  wire [31:0] frame_word = {shift, port_serial_input_in};
  wire last_bit = (bit_count == `SCWP_LAST_BIT);
  wire [11:0] frame_header = frame_word[31:20];
  wire [3:0] frame_addr = frame_word[19:16];
  wire [15:0] frame_data = frame_word[15:0];
  wire header_ok = (frame_header == `SCWP_HEADER);
  wire frame_ok = header_ok && addr_known(frame_addr);
  wire [`SCWP_CNT_W-1:0] next_bit_count = bit_count + `SCWP_CNT_W'(1);
  wire scwp_pkg::frame_field_t cur_field = field_of(bit_count);

  // count wraps for back to back frames
  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      bit_count <= `SCWP_CNT_W'h00;
      shift <= 31'h00000000;
    end else begin
      bit_count <= next_bit_count;
      shift <= frame_word[30:0];
    end
  end

  // hold words survive select release; the toggle tells clk_in a frame
  // is ready, and the words stay put at least 32 serial clocks after it
  // commit only complete good frames
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      // a decodable reset value keeps reserved codes out of hold_addr
      hold_addr <= `SCWP_ADDR_CONFIG;
      hold_data <= 16'h0000;
      commit_toggle <= 1'b0;
    end else if (!port_select_n_in && last_bit && frame_ok) begin
      hold_addr <= frame_addr;
      hold_data <= frame_data;
      commit_toggle <= ~commit_toggle;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // internal clock domain

  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic mode_meta;
  logic ext_mode;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [15:0] output_configuration;
  logic [15:0] input_offset_adjust;
  logic [15:0] full_scale_adjust;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_seen <= 1'b0;
      mode_meta <= 1'b0;
      ext_mode <= 1'b0;
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      tog_meta <= commit_toggle;
      tog_sync <= tog_meta;
      tog_seen <= tog_sync;
      mode_meta <= extended_mode_in;
      ext_mode <= mode_meta;
      pin_meta <= {single_rate_pin_in, swing_select_pin_in, edge_select_pin_in};
      pin_sync <= pin_meta;
    end
  end

  wire commit_pulse = tog_sync ^ tog_seen;
  wire commit_write = commit_pulse && ext_mode;
  wire wr_config = commit_write && (hold_addr == `SCWP_ADDR_CONFIG);
  wire wr_offset = commit_write && (hold_addr == `SCWP_ADDR_OFFSET);
  wire wr_fullscale = commit_write && (hold_addr == `SCWP_ADDR_FULLSCALE);

  // address decode into the three registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      output_configuration <= `SCWP_CFG_RESET;
      input_offset_adjust <= `SCWP_OFS_RESET;
      full_scale_adjust <= `SCWP_FSA_RESET;
    end else begin
      if (wr_config) begin
        output_configuration <= hold_data;
      end
      if (wr_offset) begin
        input_offset_adjust <= hold_data;
      end
      if (wr_fullscale) begin
        full_scale_adjust <= hold_data;
      end
    end
  end

  // in normal mode the pins rule rate, swing and edge, the other outputs hold fixed values, and the registers are bypassed
  // registers ignored in normal mode
  wire next_duty = ext_mode ? output_configuration[`SCWP_BIT_DUTY] : 1'b1;
  wire next_phase = ext_mode ? output_configuration[`SCWP_BIT_PHASE] : 1'b0;
  wire next_single = ext_mode ? output_configuration[`SCWP_BIT_SINGLE] : pin_sync[2];
  wire next_swing = ext_mode ? output_configuration[`SCWP_BIT_SWING] : pin_sync[1];
  wire next_edge = ext_mode ? output_configuration[`SCWP_BIT_EDGE] : pin_sync[0];
  wire [15:0] next_offset = ext_mode ? input_offset_adjust : `SCWP_OFS_RESET;
  wire [15:0] next_fullscale = ext_mode ? full_scale_adjust : `SCWP_FSA_RESET;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      duty_stabilizer_enable_out <= 1'b1;
      double_rate_clock_phase_out <= 1'b0;
      single_rate_select_out <= 1'b0;
      output_swing_select_out <= 1'b0;
      output_data_clock_edge_out <= 1'b0;
      offset_adjust_out <= `SCWP_OFS_RESET;
      full_scale_adjust_out <= `SCWP_FSA_RESET;
    end else begin
      duty_stabilizer_enable_out <= next_duty;
      double_rate_clock_phase_out <= next_phase;
      single_rate_select_out <= next_single;
      output_swing_select_out <= next_swing;
      output_data_clock_edge_out <= next_edge;
      offset_adjust_out <= next_offset;
      full_scale_adjust_out <= next_fullscale;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks, serial clock domain

  chk_count_wrap: assert property (
    @(posedge sclk_in) disable iff (link_rst)
    last_bit |=> (bit_count == `SCWP_CNT_W'h00)
  ) else $error("frame counter did not wrap after bit 32");

  chk_shift_msb: assert property (
    @(posedge sclk_in) disable iff (link_rst)
    (bit_count != `SCWP_CNT_W'h00) |-> (shift[0] == $past(port_serial_input_in))
  ) else $error("serial bit not shifted in at rising edge");

  chk_field_order: assert property (
    @(posedge sclk_in) disable iff (link_rst)
    (bit_count == `SCWP_HDR_LAST) && (cur_field == scwp_pkg::FIELD_HEADER)
    |=> (cur_field == scwp_pkg::FIELD_ADDR) [*4] ##1 (cur_field == scwp_pkg::FIELD_DATA)
  ) else $error("frame fields out of order");

  chk_commit_last: assert property (
    @(posedge sclk_in) disable iff (rst_in)
    (commit_toggle != $past(commit_toggle)) |-> $past(last_bit && frame_ok)
  ) else $error("frame committed before its last bit or with bad header");

  chk_hold_addr: assert property (
    @(posedge sclk_in) disable iff (rst_in)
    $changed(hold_addr) |-> addr_known(hold_addr)
  ) else $error("reserved address latched");

  chk_header_drop: assert property (
    @(posedge sclk_in) disable iff (rst_in)
    last_bit && !header_ok |=> $stable(commit_toggle)
  ) else $error("frame with a bad header was committed");

  chk_reserved_drop: assert property (
    @(posedge sclk_in) disable iff (rst_in)
    last_bit && !addr_known(frame_addr) |=> $stable(commit_toggle)
  ) else $error("frame to a reserved address was committed");

  ////////////////////////////////////////////////////////////////////////
  // checks, internal clock domain

  chk_normal_frozen: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !ext_mode |=> $stable(output_configuration) && $stable(full_scale_adjust) &&
    $stable(input_offset_adjust)
  ) else $error("register changed in normal control mode");

  chk_config_load: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_config |=> (output_configuration == $past(hold_data)) ##1
    (duty_stabilizer_enable_out == output_configuration[`SCWP_BIT_DUTY])
  ) else $error("configuration write not applied");

  chk_normal_outputs: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !ext_mode && $past(!ext_mode) |-> duty_stabilizer_enable_out &&
    !double_rate_clock_phase_out && (offset_adjust_out == `SCWP_OFS_RESET)
  ) else $error("register leaked to outputs in normal mode");

  chk_phase_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ext_mode |=> (double_rate_clock_phase_out ==
    $past(output_configuration[`SCWP_BIT_PHASE]))
  ) else $error("clock phase output mismatch");

  chk_rate_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ext_mode |=> (single_rate_select_out ==
    $past(output_configuration[`SCWP_BIT_SINGLE]))
  ) else $error("data rate output mismatch");

  chk_swing_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ext_mode |=> (output_swing_select_out ==
    $past(output_configuration[`SCWP_BIT_SWING]))
  ) else $error("swing output mismatch");

  chk_edge_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ext_mode |=> (output_data_clock_edge_out ==
    $past(output_configuration[`SCWP_BIT_EDGE]))
  ) else $error("edge output mismatch");

  chk_duty_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ext_mode |=> (duty_stabilizer_enable_out ==
    $past(output_configuration[`SCWP_BIT_DUTY]))
  ) else $error("stabiliser output mismatch");

  chk_commit_cause: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(input_offset_adjust) |-> $past(wr_offset)
  ) else $error("offset register changed without a commit");

  chk_scale_cause: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(full_scale_adjust) |-> $past(wr_fullscale)
  ) else $error("full scale register changed without a commit");

  chk_config_cause: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(output_configuration) |-> $past(wr_config)
  ) else $error("configuration register changed without a commit");

  chk_offset_load: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_offset |=> (input_offset_adjust == $past(hold_data))
  ) else $error("offset write not applied");

  chk_scale_load: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wr_fullscale |=> (full_scale_adjust == $past(hold_data))
  ) else $error("full scale write not applied");

  chk_normal_pins: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !ext_mode |=> (single_rate_select_out == $past(pin_sync[2])) &&
    (output_swing_select_out == $past(pin_sync[1])) &&
    (output_data_clock_edge_out == $past(pin_sync[0]))
  ) else $error("normal mode output does not follow its pin");

  chk_normal_scale: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !ext_mode && $past(!ext_mode) |-> (full_scale_adjust_out == `SCWP_FSA_RESET)
  ) else $error("full scale register leaked in normal mode");

  chk_adjust_map: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ext_mode |=> (offset_adjust_out == $past(input_offset_adjust)) &&
    (full_scale_adjust_out == $past(full_scale_adjust))
  ) else $error("adjust outputs do not follow their registers");

endmodule

// ### dv/scwp_host_model.sv
// Purpose: host controller model driving the serial write port
// Assumes: caller picks frame length and serial clock half period
// Notes: serial clock stands still low outside frames
`timescale 1ns/1ns

module scwp_host_model (
  output logic sclk_out,
  output logic select_n_out,
  output logic port_serial_input_out
);
  initial begin
    sclk_out = 1'b0;
    select_n_out = 1'b1;
    port_serial_input_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // select held low, msb first
  // any half period is accepted, slow ones included
  task automatic send(input logic [31:0] f, input int n, input int half, input bit hold);
    select_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      port_serial_input_out = f[31-i];
      #half sclk_out = 1'b1;
      #(half + 1) sclk_out = 1'b0;
    end
    // select may stay low into the next frame
    if (!hold) select_n_out = 1'b1;
    // released data line shows no stale bit
    port_serial_input_out = ~port_serial_input_out;
  endtask
endmodule

// ### dv/tb_serial_config_write_port.sv
// Purpose: self-checking bench for the serial configuration write port
// Assumes: outputs change in one step per committed frame or pin change
// Notes: expected output vectors are queued; a monitor pops one per change
`timescale 1ns/1ns
`include "scwp_params.svh"

module tb_serial_config_write_port;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ext_mode = 1'b1;
  logic edge_pin = 1'b0;
  logic swing_pin = 1'b0;
  logic rate_pin = 1'b0;
  logic sclk, sel_n, port_serial_input, duty, phase, single, swing, edge_sel, mon_on;
  logic [15:0] ofs, fsa, cfg_m, ofs_m, fsa_m, d;
  logic [36:0] exp_last, seen;
  logic [36:0] notes[$];
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h14418618;
  wire [36:0] outs = {duty, phase, single, swing, edge_sel, ofs, fsa};

  always #20 clk_in = ~clk_in;

  scwp_host_model i_host (.sclk_out(sclk), .select_n_out(sel_n), .port_serial_input_out(port_serial_input));

  serial_config_write_port i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .port_select_n_in(sel_n),
    .port_serial_input_in(port_serial_input), .extended_mode_in(ext_mode),
    .edge_select_pin_in(edge_pin), .swing_select_pin_in(swing_pin),
    .single_rate_pin_in(rate_pin), .duty_stabilizer_enable_out(duty),
    .double_rate_clock_phase_out(phase), .single_rate_select_out(single),
    .output_swing_select_out(swing), .output_data_clock_edge_out(edge_sel),
    .offset_adjust_out(ofs), .full_scale_adjust_out(fsa));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [36:0] model_vec();
    if (ext_mode) return {cfg_m[12:8], ofs_m, fsa_m};
    return {2'b10, rate_pin, swing_pin, edge_pin, `SCWP_OFS_RESET, `SCWP_FSA_RESET};
  endfunction

  task automatic check(input string what, input logic [36:0] got, input logic [36:0] want);
    n_compared++;
    if (got !== want) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic note_expected();
    logic [36:0] v;
    v = model_vec();
    if (v !== exp_last) notes.push_back(v);
    exp_last = v;
  endtask

  always @(negedge clk_in) begin
    if (mon_on === 1'b1 && outs !== seen) begin
      seen = outs;
      if (notes.size() == 0) check("unexpected change", seen, exp_last);
      else check("outputs", seen, notes.pop_front());
    end
  end

  task automatic drain();
    int k;
    for (k = 0; k < 60 && notes.size() != 0; k++) @(negedge clk_in);
    repeat (10) @(negedge clk_in);
    if (notes.size() != 0) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // only addresses 1..3 in extended mode change the model
  task automatic wr(input logic [3:0] a, input logic [15:0] v, input bit hold, input int half);
    if (ext_mode && a == `SCWP_ADDR_CONFIG) cfg_m = v;
    if (ext_mode && a == `SCWP_ADDR_OFFSET) ofs_m = v;
    if (ext_mode && a == `SCWP_ADDR_FULLSCALE) fsa_m = v;
    note_expected();
    @(negedge clk_in);
    i_host.send({`SCWP_HEADER, a, v}, 32, half, hold);
  endtask

  task automatic bad(input logic [31:0] f, input int n);
    @(negedge clk_in);
    i_host.send(f, n, 7, 0);
    drain();
  endtask

  task automatic do_reset(input logic ext);
    mon_on = 1'b0;
    @(negedge clk_in);
    rst_in = 1'b1;
    ext_mode = ext;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    cfg_m = `SCWP_CFG_RESET;
    ofs_m = `SCWP_OFS_RESET;
    fsa_m = `SCWP_FSA_RESET;
    notes.delete();
    exp_last = model_vec();
    repeat (6) @(negedge clk_in);
    seen = outs;
    check("after reset", seen, exp_last);
    mon_on = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    mon_on = 1'b0;
    // mode pin settled before reset release, never switched while running
    do_reset(1'b1);
    // nothing calibrates in this bench, so frames never wait
    // first use writes all three registers back to back
    wr(4'h1, 16'hB6FF, 1, 7);
    wr(4'h2, 16'($random(seed)), 1, 7);
    wr(4'h3, 16'($random(seed)), 0, 7);
    drain();
    for (int i = 0; i < 12; i++) begin
      d = 16'($random(seed));
      // bit 8 cleared whenever double rate is chosen
      if (!d[10]) d[8] = 1'b0;
      wr(4'(i % 3 + 1), d, i[0], (i == 5) ? 400 : 7);
      drain();
    end
    bad({12'h003, 4'h1, 16'h0000}, 32);
    bad({`SCWP_HEADER, 4'h1, 16'h0000}, 31);
    for (int a = 0; a < 16; a++) begin
      if (a > 3 || a == 0) bad({`SCWP_HEADER, 4'(a), 16'h0000}, 32);
    end
    wr(4'h1, 16'hA1FF, 0, 7);
    drain();
    // normal mode follows the pins and ignores frames
    do_reset(1'b0);
    edge_pin = 1'b1;
    note_expected();
    drain();
    swing_pin = 1'b1;
    note_expected();
    drain();
    rate_pin = 1'b1;
    note_expected();
    drain();
    wr(4'h1, 16'h0000, 0, 7);
    drain();
    check("cfg kept", {21'h0, i_dut.output_configuration}, {21'h0, `SCWP_CFG_RESET});
    do_reset(1'b1);
    tally_and_finish();
  end
endmodule
